//--- verilog/boot_alive_defs.svh
`ifndef BOOT_ALIVE_DEFS_SVH
`define BOOT_ALIVE_DEFS_SVH

`define SYS_CLK_MHZ 250
`define ALIVE_PERIOD_MS 170
`define FS_32K_HZ 32000
`define FS_44K1_HZ 44100
`define FS_48K_HZ 48000
`define ALIVE_CNT_W 12
`define FRAME_TIMEOUT_US 1000
`define FRAME_TIMEOUT_CYC (`FRAME_TIMEOUT_US * `SYS_CLK_MHZ)
`define FRAME_TMO_W 20
`define FS_SEL_32K 2'h0
`define FS_SEL_44K1 2'h1
`define FS_SEL_48K 2'h2

`endif

//--- verilog/boot_alive_pkg.sv
`include "boot_alive_defs.svh"

package boot_alive_pkg;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN = 2'b10
  } boot_state_e;

  typedef logic [`ALIVE_CNT_W-1:0] alive_cnt_t;

  // Frames per half cycle of the alive pulse; 44.1 kHz rounds down
  function automatic alive_cnt_t half_count(input logic [1:0] fs_sel);
    int hz;
    hz = `FS_48K_HZ;
    if (fs_sel == `FS_SEL_32K) begin
      hz = `FS_32K_HZ;
    end else if (fs_sel == `FS_SEL_44K1) begin
      hz = `FS_44K1_HZ;
    end
    return alive_cnt_t'((`ALIVE_PERIOD_MS * hz) / 2000);
  endfunction

endpackage

//--- verilog/frame_edge_tracker.sv
`include "boot_alive_defs.svh"

module frame_edge_tracker
  import boot_alive_pkg::*;
#(
  parameter logic [`FRAME_TMO_W-1:0] TIMEOUT_CYC = `FRAME_TMO_W'(`FRAME_TIMEOUT_CYC)
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic audio_frame_clock,
  output logic frame_tick,
  output logic frame_active
);

  logic frame_ff;
  logic nxt_frame;
  logic tick_ff;
  logic nxt_tick;
  logic active_ff;
  logic nxt_active;
  logic [`FRAME_TMO_W-1:0] idle_cnt_ff;
  logic [`FRAME_TMO_W-1:0] nxt_idle_cnt;

  always_comb begin
    nxt_frame = audio_frame_clock;
    nxt_tick = audio_frame_clock && !frame_ff;
    nxt_idle_cnt = idle_cnt_ff;
    nxt_active = active_ff;
    if (tick_ff) begin
      nxt_idle_cnt = '0;
      nxt_active = 1'b1;
    end else if (idle_cnt_ff >= TIMEOUT_CYC - 1'b1) begin
      nxt_active = 1'b0;
    end else begin
      nxt_idle_cnt = idle_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      frame_ff <= 1'b0;
      tick_ff <= 1'b0;
      idle_cnt_ff <= '0;
      active_ff <= 1'b0;
    end else begin
      frame_ff <= nxt_frame;
      tick_ff <= nxt_tick;
      idle_cnt_ff <= nxt_idle_cnt;
      active_ff <= nxt_active;
    end
  end

  assign frame_tick = tick_ff;
  assign frame_active = active_ff;

endmodule

//--- verilog/boot_hold_and_alive_pulse.sv
// Operation
// - Strap high at reset: stay idle until a start command arrives.
// - Strap low at reset: run defaults at once, no command needed.
// - Default configuration starts with master volume muted.
// - After reset, drive a periodic alive pulse of about 170 ms.
// - Alive pulse paced by frame clock; stops when audio stops.
`include "boot_alive_defs.svh"

module boot_hold_and_alive_pulse
  import boot_alive_pkg::*;
#(
  parameter logic [`FRAME_TMO_W-1:0] FRAME_TIMEOUT_CYC = `FRAME_TMO_W'(`FRAME_TIMEOUT_CYC)
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic boot_hold_select,
  input wire logic audio_frame_clock,
  input wire logic [1:0] fs_select,
  input wire logic start_cmd,
  input wire logic mute_cmd,
  input wire logic unmute_cmd,
  output logic processing_active,
  output logic master_volume_mute,
  output logic audio_active,
  output logic alive_pulse_out,
  output logic alive_pulse_oe
);

  boot_state_e state_ff;
  boot_state_e nxt_state;
  logic mute_ff;
  logic nxt_mute;
  alive_cnt_t cnt_ff;
  alive_cnt_t nxt_cnt;
  logic level_ff;
  logic nxt_level;
  logic frame_tick;
  logic frame_active;
  alive_cnt_t half_cnt;

  frame_edge_tracker #(
    .TIMEOUT_CYC(FRAME_TIMEOUT_CYC)
  ) u_frame (
    .sys_clk(sys_clk),
    .reset(reset),
    .audio_frame_clock(audio_frame_clock),
    .frame_tick(frame_tick),
    .frame_active(frame_active)
  );

  assign half_cnt = half_count(fs_select);

  // Strap is caught by a clocked step after release, never by the reset itself
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_SAMPLE: begin
        if (boot_hold_select) begin
          nxt_state = ST_HOLD;
        end else begin
          nxt_state = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (start_cmd) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_SAMPLE;
      end
    endcase
  end

  // Entering the run state forces mute; that set wins over a same-cycle unmute
  always_comb begin
    nxt_mute = mute_ff;
    if (state_ff == ST_RUN && unmute_cmd) begin
      nxt_mute = 1'b0;
    end
    if (state_ff == ST_RUN && mute_cmd) begin
      nxt_mute = 1'b1;
    end
    if (state_ff != ST_RUN && nxt_state == ST_RUN) begin
      nxt_mute = 1'b1;
    end
  end

  // Counting frame edges ties the pulse to audio activity, no sys_clk fallback
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_level = level_ff;
    if (state_ff != ST_SAMPLE && frame_tick) begin
      if (cnt_ff >= half_cnt - 1'b1) begin
        nxt_cnt = '0;
        nxt_level = !level_ff;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_SAMPLE;
      mute_ff <= 1'b1;
      cnt_ff <= '0;
      level_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mute_ff <= nxt_mute;
      cnt_ff <= nxt_cnt;
      level_ff <= nxt_level;
    end
  end

  assign processing_active = (state_ff == ST_RUN);
  assign master_volume_mute = mute_ff;
  assign audio_active = frame_active;
  // Open drain: pin only pulls low, the external pull-up gives the high half
  assign alive_pulse_out = 1'b0;
  assign alive_pulse_oe = !level_ff;

  a_hold_stays_idle: assert property (@(posedge sys_clk) disable iff (reset)
    state_ff == ST_HOLD && !start_cmd |=> state_ff == ST_HOLD && !processing_active)
    else $error("Held device left idle without a start command");

  a_start_begins_run: assert property (@(posedge sys_clk) disable iff (reset)
    state_ff == ST_HOLD && start_cmd |=> processing_active ##1 processing_active)
    else $error("Start command did not begin processing");

  a_strap_low_runs: assert property (@(posedge sys_clk) disable iff (reset)
    state_ff == ST_SAMPLE && !boot_hold_select |=> processing_active)
    else $error("Strap low did not start processing at once");

  a_boot_muted: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(processing_active) |-> master_volume_mute)
    else $error("Processing began without master mute");

  a_toggle_at_count: assert property (@(posedge sys_clk) disable iff (reset)
    state_ff != ST_SAMPLE && frame_tick && cnt_ff == half_cnt - 1'b1
      |=> level_ff != $past(level_ff) && cnt_ff == '0)
    else $error("Alive pulse missed its terminal count");

  a_no_frame_still: assert property (@(posedge sys_clk) disable iff (reset)
    !frame_tick |=> $stable(level_ff) && $stable(cnt_ff))
    else $error("Alive pulse moved without a frame edge");

  a_pin_follows: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(level_ff) |-> $past(frame_tick) && alive_pulse_oe == !level_ff
      && $past(cnt_ff) == $past(half_cnt) - 1'b1)
    else $error("Alive pin changed outside its count");

  // Strap sampling is a single clocked step and the run state only leaves by reset
  a_sample_one_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    state_ff == ST_SAMPLE |=> state_ff != ST_SAMPLE)
    else $error("Strap sampling lasted more than one cycle");

  a_strap_high_holds: assert property (@(posedge sys_clk) disable iff (reset)
    state_ff == ST_SAMPLE && boot_hold_select |=> state_ff == ST_HOLD && !processing_active)
    else $error("Strap high did not hold the device idle");

  a_state_legal: assert property (@(posedge sys_clk) disable iff (reset)
    state_ff inside {ST_SAMPLE, ST_HOLD, ST_RUN})
    else $error("Boot state left its legal codes");

  a_run_sticky: assert property (@(posedge sys_clk) disable iff (reset)
    processing_active |=> processing_active)
    else $error("Processing stopped without a reset");

  a_idle_muted: assert property (@(posedge sys_clk) disable iff (reset)
    !processing_active |-> master_volume_mute)
    else $error("Master mute cleared while not processing");

  a_entry_mutes: assert property (@(posedge sys_clk) disable iff (reset)
    state_ff != ST_RUN && nxt_state == ST_RUN |=> master_volume_mute)
    else $error("Entering run did not force master mute");

  a_mute_cmd_sets: assert property (@(posedge sys_clk) disable iff (reset)
    processing_active && mute_cmd |=> master_volume_mute)
    else $error("Mute command did not mute");

  a_unmute_clears: assert property (@(posedge sys_clk) disable iff (reset)
    processing_active && unmute_cmd && !mute_cmd |=> !master_volume_mute)
    else $error("Unmute command did not clear mute");

  a_mute_holds: assert property (@(posedge sys_clk) disable iff (reset)
    processing_active && !mute_cmd && !unmute_cmd |=> $stable(master_volume_mute))
    else $error("Master mute changed without a command");

  a_pin_data_low: assert property (@(posedge sys_clk) disable iff (reset)
    alive_pulse_out == 1'b0)
    else $error("Alive pin data left its pull-low level");

  a_sample_frozen: assert property (@(posedge sys_clk) disable iff (reset)
    state_ff == ST_SAMPLE |=> $stable(level_ff) && $stable(cnt_ff))
    else $error("Alive pulse moved while sampling the strap");

  a_tick_wakes_audio: assert property (@(posedge sys_clk) disable iff (reset)
    frame_tick |=> audio_active)
    else $error("Frame edge did not mark audio active");

  a_audio_idle_frozen: assert property (@(posedge sys_clk) disable iff (reset)
    !audio_active && !frame_tick |=> $stable(level_ff))
    else $error("Alive pulse moved while audio was idle");

  a_count_steps: assert property (@(posedge sys_clk) disable iff (reset)
    state_ff != ST_SAMPLE && frame_tick && cnt_ff < half_cnt - 1'b1
      |=> cnt_ff == $past(cnt_ff) + 1'b1 && $stable(level_ff))
    else $error("Frame count did not advance by one");

  a_level_wrap_zero: assert property (@(posedge sys_clk) disable iff (reset)
    state_ff != ST_SAMPLE && frame_tick && cnt_ff >= half_cnt - 1'b1
      |=> cnt_ff == '0)
    else $error("Frame count did not wrap at its terminal count");

  a_tick_single: assert property (@(posedge sys_clk) disable iff (reset)
    frame_tick |=> !frame_tick)
    else $error("Frame edge counted twice");

endmodule

//--- verif/host_monitor.sv
module host_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pulse_pin,
  output logic [7:0] edge_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_ff;
  // Host counts pin changes; a count that stalls means a dead device
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prev_ff <= 1'b0;
      edge_cnt <= 8'h00;
    end else begin
      prev_ff <= pulse_pin;
      if (pulse_pin != prev_ff) begin
        edge_cnt <= edge_cnt + 8'h01;
      end
    end
  end
endmodule

//--- verif/tb_boot_hold_and_alive_pulse.sv
module tb_boot_hold_and_alive_pulse;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic strap = 1'b0;
  logic frame = 1'b0;
  logic start = 1'b0;
  logic mute = 1'b0;
  logic unmute = 1'b0;
  logic [1:0] fs = 2'h0;
  logic act, vol_mute, aud, pout, poe, pin;
  logic [7:0] edges;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  always #2 sys_clk = ~sys_clk;
  // Open-drain pin with pull-up
  assign pin = poe ? 1'b0 : 1'b1;
  boot_hold_and_alive_pulse #(.FRAME_TIMEOUT_CYC(20'h00032)) uut (
    .sys_clk(sys_clk), .reset(reset), .boot_hold_select(strap),
    .audio_frame_clock(frame), .fs_select(fs), .start_cmd(start),
    .mute_cmd(mute), .unmute_cmd(unmute), .processing_active(act),
    .master_volume_mute(vol_mute), .audio_active(aud),
    .alive_pulse_out(pout), .alive_pulse_oe(poe)
  );
  host_monitor mon (.sys_clk(sys_clk), .reset(reset), .pulse_pin(pin), .edge_cnt(edges));
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Whole run is about 42k cycles; a stalled scenario must not hide a pass
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      end_sim();
    end
  end
  task do_reset(input logic s, input logic [1:0] f);
    @(posedge sys_clk);
    reset <= 1'b1;
    strap <= s;
    fs <= f;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // Frames of four clocks keep the run short yet legal
  task frames(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      frame <= 1'b1;
      repeat (2) @(posedge sys_clk);
      frame <= 1'b0;
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
  endtask
  // One-cycle command strobes; several may share one cycle
  task pulse(input logic s_go, input logic s_mute, input logic s_unmute);
    @(posedge sys_clk);
    start <= s_go;
    mute <= s_mute;
    unmute <= s_unmute;
    @(posedge sys_clk);
    start <= 1'b0;
    mute <= 1'b0;
    unmute <= 1'b0;
    @(negedge sys_clk);
  endtask
  task t_run_default;
    do_reset(1'b0, 2'h0);
    chk(act, 1'b1, "not running");
    chk(vol_mute, 1'b1, "not muted");
    pulse(1'b0, 1'b0, 1'b1);
    chk(vol_mute, 1'b0, "unmute lost");
    pulse(1'b0, 1'b1, 1'b1);
    chk(vol_mute, 1'b1, "mute lost to unmute");
  endtask
  task t_alive_32k;
    frames(2719);
    chk(poe, 1'b1, "early toggle");
    chk(aud, 1'b1, "audio idle");
    frames(1);
    chk(poe, 1'b0, "no toggle");
    chk(edges, 8'h01, "host saw no edge");
  endtask
  task t_stall;
    repeat (60) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(aud, 1'b0, "audio still active");
    chk(poe, 1'b0, "pulse moved");
    chk(pout, 1'b0, "pin data high");
  endtask
  task t_hold_start;
    do_reset(1'b1, 2'h2);
    chk(act, 1'b0, "ran without start");
    pulse(1'b0, 1'b0, 1'b1);
    frames(4080);
    chk(poe, 1'b0, "no toggle at 48k");
    pulse(1'b1, 1'b0, 1'b1);
    chk(act, 1'b1, "start ignored");
    chk(vol_mute, 1'b1, "not muted");
    chk(edges, 8'h01, "host edge count");
  endtask
  task t_alive_44k;
    do_reset(1'b0, 2'h1);
    frames(3747);
    chk(poe, 1'b1, "early toggle at 44.1k");
    frames(1);
    chk(poe, 1'b0, "no toggle at 44.1k");
    chk(edges, 8'h01, "host edge at 44.1k");
  endtask
  initial begin
    t_run_default();
    t_alive_32k();
    t_stall();
    t_alive_44k();
    t_hold_start();
    end_sim();
  end
endmodule
